// *** hdl/bod_core.sv ***
// Purpose: Execute stage for invert, subtract-one, subtract-skip and jump
// Assumes: Register file outside; its read data for REG_ADDR is valid same cycle
// Notes:   A flushed slot executes as NOP; PC advances by one unless a jump executes
// Function
// - Decode invert_register_op, update zero flag
// - Destination bit picks accumulator or register
// - Decode subtract_one_op, update zero flag
// - subtract_one_skip_zero_op leaves flags untouched
// - Zero subtract-skip result flushes next instruction as NOP
// - jump_op loads 9-bit target into PC
// - Page bits fill PC high bits
// - jump_op takes two cycles via flush
`timescale 1ns/1ps
module bod_core
  import bod_pkg::*;
(
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic [INSTR_W-1:0] INSTR,
  input  wire logic [DATA_W-1:0]  REG_RDATA,
  input  wire logic               FLAGS_WE,
  input  wire logic [DATA_W-1:0]  FLAGS_WDATA,
  output logic      [ADDR_W-1:0]  REG_ADDR,
  output logic                    REG_WE,
  output logic      [DATA_W-1:0]  REG_WDATA,
  output logic      [DATA_W-1:0]  W_OUT,
  output logic      [DATA_W-1:0]  FLAGS_OUT,
  output logic      [PC_W-1:0]    PC_OUT,
  output logic                    FLUSH_OUT
);
  ////////////////////////////////////////////////////////////////////////
  // Decoded bundle and execute-stage state
  bod_dec_if dec_bus ();

  logic [INSTR_W-1:0] exec_word;
  logic               byte_op;
  logic               zero_op;
  logic               skip_op;
  logic               jump_op;
  logic               dest_reg;
  logic [ADDR_W-1:0]  reg_addr;

  logic [DATA_W-1:0]  result;
  logic               result_zero;
  logic               reg_we;
  logic               w_we;

  logic               flush_q;
  logic               flush_d;
  logic [DATA_W-1:0]  w_q;
  logic [DATA_W-1:0]  w_d;
  logic [DATA_W-1:0]  flags_q;
  logic [DATA_W-1:0]  flags_d;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [PC_W-1:0]    seq_pc;
  logic [PC_W-1:0]    jump_pc;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte operations route their result by the destination bit
  function automatic logic is_byte_op(
    input bod_op_type op
  );
    logic hit;
    case (op)
      BOD_INVERT:   hit = 1'b1;
      BOD_SUB_ONE:  hit = 1'b1;
      BOD_SUB_SKIP: hit = 1'b1;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Skip form excluded: it must leave every flag alone
  function automatic logic is_zero_op(
    input bod_op_type op
  );
    logic hit;
    case (op)
      BOD_INVERT:  hit = 1'b1;
      BOD_SUB_ONE: hit = 1'b1;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [DATA_W-1:0] byte_result(
    input bod_op_type        op,
    input logic [DATA_W-1:0] data
  );
    logic [DATA_W-1:0] value;
    case (op)
      BOD_INVERT:   value = ~data;
      BOD_SUB_ONE:  value = data - 8'h01;
      BOD_SUB_SKIP: value = data - 8'h01;
      default:      value = data;
    endcase
    return value;
  endfunction

  function automatic logic is_zero(
    input logic [DATA_W-1:0] data
  );
    return (data == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Flushed slot replaced by NOP so a discarded word has no effect
  assign exec_word = flush_q ? NOP_WORD : INSTR;

  bod_decode u_dec (
    .word (exec_word),
    .dec  (dec_bus)
  );

  assign byte_op  = is_byte_op(dec_bus.op);
  assign zero_op  = is_zero_op(dec_bus.op);
  assign skip_op  = (dec_bus.op == BOD_SUB_SKIP);
  assign jump_op  = (dec_bus.op == BOD_JUMP);
  assign dest_reg = dec_bus.dest_reg;
  assign reg_addr = dec_bus.addr;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic

  assign result      = byte_result(dec_bus.op, REG_RDATA);
  assign result_zero = is_zero(result);

  ////////////////////////////////////////////////////////////////////////
  // Flush of the prefetched slot

  always_comb begin
    flush_d = 1'b0;
    if (skip_op) begin
      flush_d = result_zero;
    end else if (jump_op) begin
      flush_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result routing

  // Destination bit picks register write-back or accumulator
  assign reg_we = byte_op && dest_reg;
  assign w_we   = byte_op && !dest_reg;

  always_comb begin
    w_d = w_q;
    if (w_we) begin
      w_d = result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags

  // Zero update beats a software flag load in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (zero_op) begin
      flags_d[ZERO_BIT] = result_zero;
    end else if (FLAGS_WE) begin
      flags_d = FLAGS_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter

  // Page bits come from the flags as they stand before this edge
  assign seq_pc  = pc_q + 11'h001;
  assign jump_pc = {flags_q[PAGE_HI:PAGE_LO], dec_bus.target};

  always_comb begin
    pc_d = seq_pc;
    if (jump_op) begin
      pc_d = jump_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_ADDR  = reg_addr;
  assign REG_WE    = reg_we;
  assign REG_WDATA = result;
  assign W_OUT     = w_q;
  assign FLAGS_OUT = flags_q;
  assign PC_OUT    = pc_q;
  assign FLUSH_OUT = flush_q;

  ////////////////////////////////////////////////////////////////////////
  // State

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= flush_d;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      w_q <= W_RESET;
    end else begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pc_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end
endmodule

// *** pkg/bod_pkg.sv ***
// Purpose: Shared constants for the byte-op and branch decoder
// Assumes: 12-bit instruction words, 8-bit data, 11-bit program counter
// Notes:   Opcode patterns compare against the masked upper bits of the word
package bod_pkg;
  localparam int          INSTR_W       = 12;
  localparam int          DATA_W        = 8;
  localparam int          PC_W          = 11;
  localparam int          ADDR_W        = 5;
  localparam int          DEST_BIT      = 5;
  localparam int          PAGE_HI       = 6;
  localparam int          PAGE_LO       = 5;
  localparam logic [5:0]  OPC_INVERT    = 6'h09;
  localparam logic [5:0]  OPC_SUB_ONE   = 6'h03;
  localparam logic [5:0]  OPC_SUB_SKIP  = 6'h0B;
  localparam logic [2:0]  OPC_JUMP      = 3'h5;
  localparam logic [11:0] NOP_WORD      = 12'h000;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [10:0] PC_RESET      = 11'h000;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam int          ZERO_BIT      = 2;

  typedef enum logic [2:0] {
    BOD_NONE, BOD_INVERT, BOD_SUB_ONE, BOD_SUB_SKIP, BOD_JUMP
  } bod_op_type;
endpackage

// *** pkg/bod_dec_if.sv ***
// Purpose: Decoded-instruction bundle between the decoder and the top
// Assumes: Single clock domain
// Notes:   Purely combinational fields
`timescale 1ns/1ps
interface bod_dec_if;
  import bod_pkg::*;
  bod_op_type        op;
  logic              dest_reg;
  logic [ADDR_W-1:0] addr;
  logic [8:0]        target;
  modport dec (output op, output dest_reg, output addr, output target);
  modport use_side (input op, input dest_reg, input addr, input target);
endinterface

// *** hdl/bod_decode.sv ***
// Purpose: Opcode matcher for the four supported instructions
// Assumes: Word is stable during the cycle it is executed
// Notes:   Unknown words decode as none and change nothing but the PC
`timescale 1ns/1ps
module bod_decode
  import bod_pkg::*;
(
  input  wire logic [INSTR_W-1:0] word,
  bod_dec_if.dec                  dec
);
  always_comb begin
    dec.dest_reg = word[DEST_BIT];
    dec.addr     = word[ADDR_W-1:0];
    dec.target   = word[8:0];
    if (word[11:9] == OPC_JUMP) begin
      dec.op = BOD_JUMP;
    end else if (word[11:6] == OPC_INVERT) begin
      dec.op = BOD_INVERT;
    end else if (word[11:6] == OPC_SUB_ONE) begin
      dec.op = BOD_SUB_ONE;
    end else if (word[11:6] == OPC_SUB_SKIP) begin
      dec.op = BOD_SUB_SKIP;
    end else begin
      dec.op = BOD_NONE;
    end
  end
endmodule

// *** test/bod_core_monitor.sv ***
// Purpose: Port checker for bod_core
// Assumes: One clock domain
// Notes:   Bound after the module
`timescale 1ns/1ps
module bod_core_monitor
  import bod_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [11:0] INSTR,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        FLAGS_WE,
  input wire logic [7:0]  FLAGS_WDATA,
  input wire logic [4:0]  REG_ADDR,
  input wire logic        REG_WE,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  W_OUT,
  input wire logic [7:0]  FLAGS_OUT,
  input wire logic [10:0] PC_OUT,
  input wire logic        FLUSH_OUT
);
  wire live = !FLUSH_OUT;
  wire inv  = live && INSTR[11:6] == OPC_INVERT;
  wire sub  = live && INSTR[11:6] == OPC_SUB_ONE;
  wire skp  = live && INSTR[11:6] == OPC_SUB_SKIP;
  wire jmp  = live && INSTR[11:9] == OPC_JUMP;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence skip_zero;
    skp && REG_RDATA == 8'h01;
  endsequence
  inv_reg_a: assert property (inv |-> REG_WE == INSTR[5] && REG_WDATA == ~REG_RDATA)
    else $error("inv");
  sub_reg_a: assert property (sub |-> REG_WE == INSTR[5] && REG_WDATA == REG_RDATA - 8'h01)
    else $error("sub");
  inv_w_a: assert property (inv && !INSTR[5] |=> W_OUT == ~$past(REG_RDATA))
    else $error("w");
  sub_z_a: assert property (sub |=> FLAGS_OUT[2] == ($past(REG_RDATA) == 8'h01))
    else $error("z");
  skip_flag_a: assert property (skp && !FLAGS_WE |=> $stable(FLAGS_OUT))
    else $error("flags");
  skip_nop_a: assert property (skip_zero |=> FLUSH_OUT && !REG_WE)
    else $error("skip");
  jump_pc_a: assert property (jmp |=>
    PC_OUT == {$past(FLAGS_OUT[6:5]), $past(INSTR[8:0])}) else $error("pc");
  jump_two_a: assert property (jmp |=> FLUSH_OUT ##1 !FLUSH_OUT)
    else $error("jump");
endmodule
bind bod_core bod_core_monitor i_mon (.*);

// *** test/byte_op_and_branch_decode_tb_top.sv ***
// Purpose: Directed bench for bod_core
// Assumes: Results show one edge after execution
// Notes:   Flags preloaded for page bits
`timescale 1ns/1ps
module byte_op_and_branch_decode_tb_top
  import bod_pkg::*;
;
  localparam int TIMEOUT_CYCLES = 300;
  logic        CLOCK = 1'b0, RST = 1'b1, FLAGS_WE = 1'b0, REG_WE, FLUSH_OUT;
  logic [11:0] INSTR = 12'h000;
  logic [7:0]  REG_RDATA = 8'h00, FLAGS_WDATA = 8'h00, REG_WDATA, W_OUT, FLAGS_OUT;
  logic [4:0]  REG_ADDR;
  logic [10:0] PC_OUT;
  int          miscompares = 0, checks = 0, cycles = 0;
  bod_core i_dut (.*);
  initial forever #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk_bit(string n, logic e, logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_data(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_pc(string n, logic [10:0] e, logic [10:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // All inputs move together on the edge; looks are taken 1 ns later
  task automatic go(logic [11:0] i, logic [7:0] r, logic fwe, logic [7:0] fdata);
    @(posedge CLOCK);
    INSTR <= i;
    REG_RDATA <= r;
    FLAGS_WE <= fwe;
    FLAGS_WDATA <= fdata;
    #1;
  endtask
  task automatic invert_case();
    go(12'h263, 8'hFF, 1'b0, 8'h00);
    chk_bit("inv we", 1'b1, REG_WE);
    chk_data("inv wdata", 8'h00, REG_WDATA);
    chk_data("inv addr", 8'h03, {3'h0, REG_ADDR});
    go(12'h243, 8'h13, 1'b0, 8'h00);
    chk_bit("inv z", 1'b1, FLAGS_OUT[ZERO_BIT]);
    chk_bit("inv we0", 1'b0, REG_WE);
  endtask
  task automatic decrement_case();
    go(12'h0E1, 8'h01, 1'b0, 8'h00);
    chk_data("inv w", 8'hEC, W_OUT);
    chk_bit("inv nz", 1'b0, FLAGS_OUT[ZERO_BIT]);
    chk_data("dec wdata", 8'h00, REG_WDATA);
    go(12'h0C1, 8'h00, 1'b0, 8'h00);
    chk_bit("dec z1", 1'b1, FLAGS_OUT[ZERO_BIT]);
    go(NOP_WORD, 8'h00, 1'b0, 8'h00);
    chk_data("dec w", 8'hFF, W_OUT);
    chk_bit("dec z", 1'b0, FLAGS_OUT[ZERO_BIT]);
  endtask
  task automatic skip_case();
    go(NOP_WORD, 8'h00, 1'b1, 8'h24);
    go(12'h2C5, 8'h01, 1'b0, 8'h00);
    chk_bit("skip we", 1'b0, REG_WE);
    chk_data("skip wdata", 8'h00, REG_WDATA);
    go(12'h263, 8'h00, 1'b0, 8'h00);
    chk_bit("skip flush", 1'b1, FLUSH_OUT);
    chk_bit("skip nop", 1'b0, REG_WE);
    chk_data("skip addr", 8'h00, {3'h0, REG_ADDR});
    chk_data("skip w", 8'h00, W_OUT);
  endtask
  task automatic jump_case();
    go(12'hA12, 8'h00, 1'b0, 8'h00);
    chk_data("skip flags", 8'h24, FLAGS_OUT);
    chk_bit("skip done", 1'b0, FLUSH_OUT);
    go(12'h263, 8'h00, 1'b0, 8'h00);
    chk_pc("jump pc", 11'h212, PC_OUT);
    chk_bit("jump flush", 1'b1, FLUSH_OUT);
    chk_bit("jump nop", 1'b0, REG_WE);
    go(NOP_WORD, 8'h00, 1'b0, 8'h00);
    chk_pc("jump next", 11'h213, PC_OUT);
    chk_bit("jump done", 1'b0, FLUSH_OUT);
  endtask
  task automatic reset_case();
    @(posedge CLOCK);
    RST <= 1'b1;
    INSTR <= NOP_WORD;
    #1;
    chk_pc("reset pc", PC_RESET, PC_OUT);
    chk_data("reset w", W_RESET, W_OUT);
    chk_data("reset flags", FLAGS_RESET, FLAGS_OUT);
    chk_bit("reset flush", 1'b0, FLUSH_OUT);
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    go(NOP_WORD, 8'h00, 1'b0, 8'h00);
    chk_pc("pc step", PC_RESET + 11'h001, PC_OUT);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    invert_case();
    decrement_case();
    skip_case();
    jump_case();
    reset_case();
    tally_and_finish();
  end
endmodule
